// [design/odc_pkg.sv]
package odc_pkg;
    // Command opcodes sent with dc low
    localparam logic [7:0] CMD_LOW_COL     = 8'h00;
    localparam logic [7:0] CMD_HIGH_COL    = 8'h10;
    localparam logic [7:0] CMD_SCROLL_OFF  = 8'h2E;
    localparam logic [7:0] CMD_SCROLL_ON   = 8'h2F;
    localparam logic [7:0] CMD_SCROLL_SET  = 8'h26;
    localparam logic [7:0] CMD_START_LINE  = 8'h40;
    localparam logic [7:0] CMD_CONTRAST    = 8'h81;
    localparam logic [7:0] CMD_PULSE_TABLE = 8'h91;
    localparam logic [7:0] CMD_BANK_PAGE0  = 8'h92;
    localparam logic [7:0] CMD_BANK_PAGE1  = 8'h93;
    localparam logic [7:0] CMD_REMAP       = 8'hA0;
    localparam logic [7:0] CMD_ENTIRE_ON   = 8'hA4;
    localparam logic [7:0] CMD_INVERSE     = 8'hA6;
    localparam logic [7:0] CMD_MUX         = 8'hA8;
    localparam logic [7:0] CMD_DCDC        = 8'hAD;
    localparam logic [7:0] CMD_DISPLAY     = 8'hAE;
    localparam logic [7:0] CMD_PAGE        = 8'hB0;
    localparam logic [7:0] CMD_SCAN_DIR    = 8'hC0;
    localparam logic [7:0] CMD_OFFSET      = 8'hD3;
    localparam logic [7:0] CMD_CLK_DIV     = 8'hD5;
    localparam logic [7:0] CMD_AREA_POWER  = 8'hD8;
    localparam logic [7:0] CMD_PRECHARGE   = 8'hD9;
    localparam logic [7:0] CMD_ROW_PINS    = 8'hDA;
    localparam logic [7:0] CMD_DESELECT    = 8'hDB;
    localparam logic [7:0] CMD_LOCK        = 8'hFD;
    // Parameter counts
    localparam logic [2:0] NPAR_ONE        = 3'h1;
    localparam logic [2:0] NPAR_LUT        = 3'h4;
    localparam logic [2:0] NPAR_BANK       = 3'h4;
    localparam logic [2:0] NPAR_SCROLL     = 3'h4;
    // Geometry
    localparam int         NUM_COLS        = 104;
    localparam int         NUM_PAGES       = 6;
    localparam int         NUM_ROWS        = 48;
    localparam int         SCROLL_COLS     = 96;
    localparam logic [6:0] LAST_COL        = 7'h67;
    localparam logic [5:0] LAST_ROW        = 6'h2F;
    localparam logic [5:0] FIXED_D_WIDTH   = 6'h3F;
    // Reset values
    localparam logic [7:0] RST_CONTRAST    = 8'h80;
    localparam logic [3:0] RST_PRE_PHASE   = 4'h2;
    localparam logic [6:0] RST_DESELECT    = 7'h3F;
    localparam logic [5:0] RST_MUX         = 6'h2F;
    localparam logic [5:0] RST_PULSE       = 6'h3F;
    localparam logic [3:0] RST_OSC_FREQ    = 4'h8;
    // Status fields
    localparam int         ST_LOCK_BIT     = 7;
    localparam int         ST_OFF_BIT      = 6;
    // Timing: time per dot-clock pulse-width unit in the row engine
    localparam int         CLK_HZ          = 50_000_000;
    localparam int         ROW_CLOCKS      = 64;

    typedef enum logic [1:0] {
        ODC_IDLE   = 2'b00,
        ODC_PARAM  = 2'b01
    } odc_dec_t;
endpackage : odc_pkg

// [design/odc_sync.sv]
module odc_sync
    import odc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : odc_sync

// [design/odc_clkdiv.sv]
module odc_clkdiv
    import odc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] ratio,
    output logic            tick
);
    logic [3:0] cnt_r;

    // Divide by ratio plus one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            tick  <= 1'b0;
        end else if (cnt_r >= ratio) begin
            cnt_r <= 4'h0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            tick  <= 1'b0;
        end
    end
endmodule : odc_clkdiv

// [design/odc_decoder.sv]
module odc_decoder
    import odc_pkg::*;
(
    input  wire logic         CLOCK,
    input  wire logic         RESETN,
    input  wire logic         SERIAL_MODE,
    input  wire logic         HOST_STB,
    input  wire logic         HOST_DC,
    input  wire logic         HOST_RW,
    input  wire logic [7:0]   HOST_WDATA,
    input  wire logic         READ_MODIFY_WRITE,
    output logic      [7:0]   HOST_RDATA,
    output logic              HOST_RVALID,
    output logic      [103:0] COLUMN_DRIVER_OUTPUT,
    output logic      [103:0] COLUMN_DRIVER_OUTPUT_OE,
    output logic      [47:0]  ROW_DRIVER_OUTPUT,
    output logic      [47:0]  ROW_DRIVER_OUTPUT_OE,
    output logic      [7:0]   CONTRAST,
    output logic      [6:0]   DESELECT_LEVEL,
    output logic      [3:0]   PRE_PHASE1,
    output logic      [3:0]   PRE_PHASE2,
    output logic      [3:0]   OSC_FREQ,
    output logic              AREA_COLOUR,
    output logic              LOW_POWER,
    output logic              ROW_PINS_ALT,
    output logic      [5:0]   ROW_PULSE_WIDTH,
    output logic              SCROLL_ACTIVE,
    output logic              DCLK_TICK
);
    logic         ser_s;
    logic         stb_s;
    logic         dc_s;
    logic         rw_s;
    logic [7:0]   wd_s;
    logic         rmw_s;
    logic         stb_d_r;
    logic         stb_q_r;
    logic         acc;
    logic         cmd_wr;
    logic         dat_wr;
    logic         dat_rd;
    logic         sta_rd;
    odc_dec_t     st_r;
    logic [7:0]   op_r;
    logic [2:0]   pcnt_r;
    logic [2:0]   pneed;
    logic [7:0]   ram_r [NUM_PAGES*NUM_COLS];
    logic [6:0]   col_r;
    logic [2:0]   page_r;
    logic [5:0]   offset_r;
    logic [3:0]   div_r;
    logic [3:0]   ph1_r;
    logic [3:0]   ph2_r;
    logic         alt_r;
    logic [6:0]   desel_r;
    logic         lock_r;
    logic         on_r;
    logic [5:0]   start_r;
    logic [7:0]   contrast_r;
    logic [5:0]   lut_r [4];
    logic [25:0]  bank0_r;
    logic [25:0]  bank1_r;
    logic         remap_r;
    logic         entire_r;
    logic         inverse_r;
    logic [5:0]   mux_r;
    logic         scan_r;
    logic         scroll_r;
    logic         sdir_r;
    logic [2:0]   s_start_r;
    logic [2:0]   s_end_r;
    logic [1:0]   s_int_r;
    logic [3:0]   s_step_r;
    logic [7:0]   rd_buf_r;
    logic [5:0]   row_r;
    logic [5:0]   row_cnt_r;
    logic         tick;
    logic [5:0]   ram_row;
    logic [5:0]   pin_row;
    logic [5:0]   scan_row;
    logic [6:0]   col_nxt;
    logic [1:0]   bank_col;

    odc_sync #(.W(13)) u_sync (
        .clk   (CLOCK),
        .rst_n (RESETN),
        .d     ({SERIAL_MODE, HOST_STB, HOST_DC, HOST_RW, HOST_WDATA, READ_MODIFY_WRITE}),
        .q     ({ser_s, stb_s, dc_s, rw_s, wd_s, rmw_s})
    );

    odc_clkdiv u_div (
        .clk   (CLOCK),
        .rst_n (RESETN),
        .ratio (div_r),
        .tick  (tick)
    );

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            stb_d_r <= 1'b0;
            stb_q_r <= 1'b0;
        end else begin
            stb_d_r <= stb_s;
            stb_q_r <= stb_d_r;
        end
    end

    // Taken one cycle late so every synced data bit has settled
    assign acc    = stb_d_r & ~stb_q_r;
    assign cmd_wr = acc & ~dc_s & (~rw_s | ser_s);
    assign dat_wr = acc & dc_s & (~rw_s | ser_s);
    assign dat_rd = acc & dc_s & rw_s & ~ser_s;
    assign sta_rd = acc & ~dc_s & rw_s & ~ser_s;

    always_comb begin
        case (wd_s)
            CMD_OFFSET, CMD_CLK_DIV, CMD_PRECHARGE, CMD_ROW_PINS, CMD_AREA_POWER,
            CMD_DESELECT, CMD_CONTRAST, CMD_MUX, CMD_DCDC, CMD_LOCK: pneed = NPAR_ONE;
            CMD_PULSE_TABLE:                 pneed = NPAR_LUT;
            CMD_BANK_PAGE0, CMD_BANK_PAGE1:  pneed = NPAR_BANK;
            CMD_SCROLL_SET:                  pneed = NPAR_SCROLL;
            default:                         pneed = 3'h0;
        endcase
    end

    // Opcode or parameter phase
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            st_r   <= ODC_IDLE;
            op_r   <= 8'h00;
            pcnt_r <= 3'h0;
        end else if (cmd_wr) begin
            case (st_r)
                ODC_IDLE: begin
                    op_r   <= wd_s;
                    pcnt_r <= 3'h0;
                    if (pneed != 3'h0 && (!lock_r || wd_s == CMD_LOCK)) begin
                        st_r <= ODC_PARAM;
                    end
                end
                ODC_PARAM: begin
                    pcnt_r <= pcnt_r + 3'h1;
                    if (pcnt_r + 3'h1 >= pneed_of(op_r)) begin
                        st_r <= ODC_IDLE;
                    end
                end
                default: st_r <= ODC_IDLE;
            endcase
        end
    end

    function automatic logic [2:0] pneed_of(input logic [7:0] op);
        case (op)
            CMD_PULSE_TABLE:                pneed_of = NPAR_LUT;
            CMD_BANK_PAGE0, CMD_BANK_PAGE1: pneed_of = NPAR_BANK;
            CMD_SCROLL_SET:                 pneed_of = NPAR_SCROLL;
            default:                        pneed_of = NPAR_ONE;
        endcase
    endfunction : pneed_of

    // Configuration registers
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            offset_r <= 6'h00;
            div_r <= 4'h0; OSC_FREQ <= RST_OSC_FREQ;
            ph1_r <= RST_PRE_PHASE; ph2_r <= RST_PRE_PHASE;
            alt_r <= 1'b1; desel_r <= RST_DESELECT;
            lock_r <= 1'b0; on_r <= 1'b0; start_r <= 6'h00;
            contrast_r <= RST_CONTRAST;
            lut_r <= '{default: RST_PULSE};
            bank0_r <= '0; bank1_r <= '0;
            remap_r <= 1'b0; entire_r <= 1'b0; inverse_r <= 1'b0;
            mux_r <= RST_MUX; scan_r <= 1'b0; scroll_r <= 1'b0;
            sdir_r <= 1'b0; s_start_r <= 3'h0; s_end_r <= 3'h0;
            s_int_r <= 2'h0; s_step_r <= 4'h1;
            page_r <= 3'h0;
        end else if (cmd_wr && st_r == ODC_PARAM) begin
            case (op_r)
                CMD_OFFSET:    offset_r <= wd_s[5:0];
                CMD_CLK_DIV: begin
                    div_r    <= wd_s[3:0];
                    OSC_FREQ <= wd_s[7:4];
                end
                CMD_PRECHARGE: begin
                    ph1_r <= wd_s[3:0];
                    ph2_r <= wd_s[7:4];
                end
                CMD_ROW_PINS:  alt_r <= wd_s[4];
                CMD_DESELECT:  desel_r <= wd_s[6:0];
                CMD_CONTRAST:  contrast_r <= wd_s;
                CMD_MUX:       mux_r <= wd_s[5:0];
                CMD_LOCK:      lock_r <= wd_s[2];
                CMD_PULSE_TABLE: lut_r[pcnt_r[1:0]] <= wd_s[5:0];
                CMD_BANK_PAGE0: bank0_r[pcnt_r[1:0]*8 +: 2] <= wd_s[1:0];
                CMD_BANK_PAGE1: bank1_r[pcnt_r[1:0]*8 +: 2] <= wd_s[1:0];
                CMD_SCROLL_SET: begin
                    case (pcnt_r)
                        3'h0: s_step_r  <= wd_s[3:0];
                        3'h1: s_start_r <= wd_s[2:0];
                        3'h2: s_int_r   <= wd_s[1:0];
                        default: s_end_r <= wd_s[2:0];
                    endcase
                end
                default: ;
            endcase
        end else if (cmd_wr && !lock_r) begin
            if (wd_s[7:4] == 4'h0 || wd_s[7:4] == 4'h1) begin
            end else if (wd_s == CMD_SCROLL_ON) begin
                scroll_r <= 1'b1;
            end else if (wd_s == CMD_SCROLL_OFF) begin
                scroll_r <= 1'b0;
            end else if (wd_s[7:6] == 2'b01) begin
                start_r <= (wd_s[5:0] > LAST_ROW) ? LAST_ROW : wd_s[5:0];
            end else if (wd_s[7:1] == CMD_REMAP[7:1]) begin
                remap_r <= wd_s[0];
            end else if (wd_s[7:1] == CMD_ENTIRE_ON[7:1]) begin
                entire_r <= wd_s[0];
            end else if (wd_s[7:1] == CMD_INVERSE[7:1]) begin
                inverse_r <= wd_s[0];
            end else if (wd_s[7:1] == CMD_DISPLAY[7:1]) begin
                on_r <= wd_s[0];
            end else if (wd_s[7:3] == CMD_PAGE[7:3] && wd_s[2:0] < 3'h6) begin
                page_r <= wd_s[2:0];
            end else if (wd_s[7:4] == CMD_SCAN_DIR[7:4]) begin
                scan_r <= wd_s[3];
            end
        end else if (cmd_wr && lock_r && st_r == ODC_IDLE) begin
        end
    end

    // D8 mode bits arrive as its parameter byte
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            AREA_COLOUR <= 1'b0;
            LOW_POWER   <= 1'b0;
        end else if (cmd_wr && st_r == ODC_PARAM && op_r == CMD_AREA_POWER) begin
            AREA_COLOUR <= (wd_s[5:4] == 2'b11);
            LOW_POWER   <= wd_s[2] & wd_s[0];
        end
    end

    // Column pointer
    assign col_nxt = (col_r == LAST_COL) ? 7'h00 : col_r + 7'h01;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            col_r <= 7'h00;
        end else if (cmd_wr && st_r == ODC_IDLE && !lock_r && wd_s[7:4] == 4'h0) begin
            col_r <= {col_r[6:4], wd_s[3:0]};
        end else if (cmd_wr && st_r == ODC_IDLE && !lock_r && wd_s[7:4] == 4'h1) begin
            col_r <= {wd_s[2:0], col_r[3:0]};
        end else if (dat_wr) begin
            col_r <= col_nxt;
        end else if (dat_rd && !rmw_s) begin
            col_r <= col_nxt;
        end
    end

    // Display RAM and read pipe, first read returns stale buffer
    always_ff @(posedge CLOCK) begin
        if (dat_wr) begin
            ram_r[page_r*NUM_COLS + col_r] <= wd_s;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rd_buf_r    <= 8'h00;
            HOST_RDATA  <= 8'h00;
            HOST_RVALID <= 1'b0;
        end else begin
            HOST_RVALID <= dat_rd | sta_rd;
            if (dat_rd) begin
                HOST_RDATA <= rd_buf_r;
                rd_buf_r   <= ram_r[page_r*NUM_COLS + col_r];
            end else if (sta_rd) begin
                HOST_RDATA <= {lock_r, ~on_r, 6'h00};
            end
        end
    end

    // Row scan engine
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            row_r     <= 6'h00;
            row_cnt_r <= 6'h00;
        end else if (tick) begin
            row_cnt_r <= row_cnt_r + 6'h01;
            if (row_cnt_r == FIXED_D_WIDTH) begin
                row_r <= (row_r >= mux_r) ? 6'h00 : row_r + 6'h01;
            end
        end
    end

    assign scan_row = scan_r ? mux_r - row_r : row_r;
    assign pin_row  = 6'((scan_row + offset_r) % NUM_ROWS);
    assign ram_row  = 6'((row_r + start_r) % NUM_ROWS);
    assign bank_col = ram_row[3] ? bank1_r[1:0] : bank0_r[1:0];

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            COLUMN_DRIVER_OUTPUT <= '0;
            ROW_DRIVER_OUTPUT    <= '0;
            ROW_PULSE_WIDTH      <= RST_PULSE;
        end else begin
            for (int c = 0; c < NUM_COLS; c++) begin
                logic px;
                logic [6:0] src;
                px  = 1'b0;
                src = remap_r ? 7'(LAST_COL - c) : 7'(c);
                if (scroll_r && src >= SCROLL_COLS) begin
                    px = 1'b0;
                end else begin
                    px = ram_r[ram_row[5:3]*NUM_COLS + src][ram_row[2:0]] ^ inverse_r;
                end
                COLUMN_DRIVER_OUTPUT[c] <= entire_r | px;
            end
            ROW_DRIVER_OUTPUT <= 48'h1 << pin_row;
            if (AREA_COLOUR && ram_row[5:4] == 2'b00) begin
                ROW_PULSE_WIDTH <= (bank_col == 2'b11) ? FIXED_D_WIDTH : lut_r[bank_col + 2'h1];
            end else begin
                ROW_PULSE_WIDTH <= lut_r[0];
            end
        end
    end

    assign COLUMN_DRIVER_OUTPUT_OE = {104{on_r}};
    assign ROW_DRIVER_OUTPUT_OE    = {48{on_r}};
    assign CONTRAST       = contrast_r;
    assign DESELECT_LEVEL = desel_r;
    assign PRE_PHASE1     = ph1_r;
    assign PRE_PHASE2     = ph2_r;
    assign ROW_PINS_ALT   = alt_r;
    assign SCROLL_ACTIVE  = scroll_r;
    assign DCLK_TICK      = tick;
endmodule : odc_decoder

// [testbench/odc_decoder_sva.sv]
module odc_decoder_sva
    import odc_pkg::*;
(
    input  wire logic         CLOCK,
    input  wire logic         RESETN,
    input  wire logic         SERIAL_MODE,
    input  wire logic         HOST_STB,
    input  wire logic         HOST_DC,
    input  wire logic         HOST_RW,
    input  wire logic [7:0]   HOST_RDATA,
    input  wire logic         HOST_RVALID,
    input  wire logic [103:0] COLUMN_DRIVER_OUTPUT_OE,
    input  wire logic [47:0]  ROW_DRIVER_OUTPUT,
    input  wire logic [47:0]  ROW_DRIVER_OUTPUT_OE,
    input  wire logic [7:0]   CONTRAST,
    input  wire logic [6:0]   DESELECT_LEVEL,
    input  wire logic [3:0]   PRE_PHASE1,
    input  wire logic [3:0]   PRE_PHASE2,
    input  wire logic [3:0]   OSC_FREQ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    logic [26:0] cfg;
    assign cfg = {CONTRAST, DESELECT_LEVEL, PRE_PHASE1, PRE_PHASE2, OSC_FREQ};
    // Parallel read request after a settled parallel mode
    sequence s_rd_req;
        $rose(HOST_STB) && HOST_RW && !SERIAL_MODE && !$past(SERIAL_MODE, 4);
    endsequence
    sequence s_serial;
        SERIAL_MODE[*6];
    endsequence
    sequence s_cmd_prev;
        $past(HOST_STB) && !$past(HOST_DC) && !$past(HOST_RW);
    endsequence
    a_read_answer: assert property (s_rd_req |-> ##[2:5] HOST_RVALID)
        else $error("read got no answer");
    a_serial_noread: assert property (s_serial |-> !HOST_RVALID)
        else $error("answer in serial mode");
    a_cfg_by_cmd: assert property ($changed(cfg) |-> s_cmd_prev)
        else $error("setting moved without command write");
    a_oe_by_cmd: assert property ($changed(ROW_DRIVER_OUTPUT_OE) |-> s_cmd_prev)
        else $error("enable moved without command write");
    a_oe_uniform: assert property ((&COLUMN_DRIVER_OUTPUT_OE && &ROW_DRIVER_OUTPUT_OE)
        || !(|{COLUMN_DRIVER_OUTPUT_OE, ROW_DRIVER_OUTPUT_OE}))
        else $error("driver enables disagree");
    a_status_bits: assert property (HOST_RVALID && !$past(HOST_DC, 2) |->
        HOST_RDATA[ST_OFF_BIT] == !ROW_DRIVER_OUTPUT_OE[0] && HOST_RDATA[5:0] == 6'h00)
        else $error("status bits wrong");
    a_row_onehot: assert property (ROW_DRIVER_OUTPUT_OE[0] |-> $onehot0(ROW_DRIVER_OUTPUT))
        else $error("several rows driven");
    a_rvalid_pulse: assert property (HOST_RVALID |=> !HOST_RVALID)
        else $error("answer longer than one cycle");
    a_rdata_hold: assert property (!HOST_RVALID |-> $stable(HOST_RDATA))
        else $error("read data moved without answer");
endmodule : odc_decoder_sva

bind odc_decoder odc_decoder_sva odc_decoder_sva_inst (
    .CLOCK(CLOCK), .RESETN(RESETN), .SERIAL_MODE(SERIAL_MODE), .HOST_STB(HOST_STB),
    .HOST_DC(HOST_DC), .HOST_RW(HOST_RW), .HOST_RDATA(HOST_RDATA),
    .HOST_RVALID(HOST_RVALID), .COLUMN_DRIVER_OUTPUT_OE(COLUMN_DRIVER_OUTPUT_OE),
    .ROW_DRIVER_OUTPUT(ROW_DRIVER_OUTPUT), .ROW_DRIVER_OUTPUT_OE(ROW_DRIVER_OUTPUT_OE),
    .CONTRAST(CONTRAST), .DESELECT_LEVEL(DESELECT_LEVEL), .PRE_PHASE1(PRE_PHASE1),
    .PRE_PHASE2(PRE_PHASE2), .OSC_FREQ(OSC_FREQ)
);

// [testbench/odc_host.sv]
module odc_host
    import odc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid,
    output logic            stb,
    output logic            dc,
    output logic            rw,
    output logic      [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        stb = 1'b0;
        dc = 1'b0;
        rw = 1'b0;
        wdata = 8'h00;
    end
    // One access: hold strobe seven edges, then gap of four
    task automatic xfer(input logic d_c, input logic r_w, input logic [7:0] d,
                        output logic [7:0] q, output logic got);
        q = 8'h00;
        got = 1'b0;
        @(negedge clk);
        dc = d_c;
        rw = r_w;
        wdata = d;
        stb = 1'b1;
        repeat (6) begin
            @(negedge clk);
            if (rvalid === 1'b1) begin
                got = 1'b1;
                q = rdata;
            end
        end
        @(negedge clk);
        stb = 1'b0;
        wdata = ~d;
        repeat (4) @(negedge clk);
    endtask : xfer
endmodule : odc_host

// [testbench/odc_decoder_test.sv]
module odc_decoder_test
    import odc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clock, resetn, serial_mode, rmw, host_stb, host_dc, host_rw;
    logic         host_rvalid, area_colour, low_power, row_pins_alt, scroll_active, dclk_tick;
    logic [7:0]   host_wdata, host_rdata, contrast;
    logic [103:0] col_out, col_oe;
    logic [47:0]  row_out, row_oe;
    logic [6:0]   deselect;
    logic [3:0]   ph1, ph2, osc;
    logic [5:0]   pulse;
    int           failures, samples_checked;
    logic [7:0]   lut_par [4] = '{8'h81, 8'hD9, 8'hAF, 8'hA5};
    logic [7:0]   scr_par [4] = '{8'h01, 8'h00, 8'h00, 8'h05};

    odc_decoder odc_decoder_inst (
        .CLOCK(clock), .RESETN(resetn), .SERIAL_MODE(serial_mode), .HOST_STB(host_stb),
        .HOST_DC(host_dc), .HOST_RW(host_rw), .HOST_WDATA(host_wdata),
        .READ_MODIFY_WRITE(rmw), .HOST_RDATA(host_rdata), .HOST_RVALID(host_rvalid),
        .COLUMN_DRIVER_OUTPUT(col_out), .COLUMN_DRIVER_OUTPUT_OE(col_oe),
        .ROW_DRIVER_OUTPUT(row_out), .ROW_DRIVER_OUTPUT_OE(row_oe), .CONTRAST(contrast),
        .DESELECT_LEVEL(deselect), .PRE_PHASE1(ph1), .PRE_PHASE2(ph2), .OSC_FREQ(osc),
        .AREA_COLOUR(area_colour), .LOW_POWER(low_power), .ROW_PINS_ALT(row_pins_alt),
        .ROW_PULSE_WIDTH(pulse), .SCROLL_ACTIVE(scroll_active), .DCLK_TICK(dclk_tick)
    );
    odc_host odc_host_inst (
        .clk(clock), .rdata(host_rdata), .rvalid(host_rvalid), .stb(host_stb),
        .dc(host_dc), .rw(host_rw), .wdata(host_wdata)
    );

    task automatic chk(input string nm, input logic [103:0] exp, input logic [103:0] got);
        samples_checked++;
        if (exp !== got) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic dc, input logic [7:0] b);
        logic [7:0] q;
        logic       g;
        odc_host_inst.xfer(dc, 1'b0, b, q, g);
    endtask : wr
    task automatic rd(input logic dc, input logic [7:0] exp, input bit use_d);
        logic [7:0] q;
        logic       g;
        odc_host_inst.xfer(dc, 1'b1, 8'h00, q, g);
        chk("answer", 104'(!serial_mode), 104'(g));
        if (use_d) begin
            chk("read", 104'(exp), 104'(q));
        end
    endtask : rd
    task automatic ptr(input logic [6:0] c);
        wr(1'b0, {4'h0, c[3:0]});
        wr(1'b0, {5'h02, c[6:4]});
    endtask : ptr
    task automatic ticks(input int exp);
        int n;
        n = 0;
        repeat (32) begin
            @(negedge clock);
            n = n + int'(dclk_tick);
        end
        chk("ticks", 104'(exp), 104'(n));
    endtask : ticks
    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #1_000_000;
        failures++;
        final_report();
    end
    initial begin
        resetn = 1'b0;
        serial_mode = 1'b0;
        rmw = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        repeat (2) @(negedge clock);
        chk("contrast", 104'(RST_CONTRAST), 104'(contrast));
        chk("deselect", 104'(7'h3F), 104'(deselect));
        chk("phases", 104'(8'h22), 104'({ph2, ph1}));
        chk("alt", 104'(1'b1), 104'(row_pins_alt));
        chk("mode", 104'(2'b00), 104'({area_colour, low_power}));
        rd(1'b0, 8'h40, 1'b1);
        ticks(32);
        wr(1'b0, CMD_CLK_DIV);
        wr(1'b0, 8'hA3);
        chk("osc", 104'(4'hA), 104'(osc));
        ticks(8);
        wr(1'b0, CMD_PRECHARGE);
        wr(1'b0, 8'h5C);
        chk("phases", 104'(8'h5C), 104'({ph2, ph1}));
        wr(1'b0, CMD_ROW_PINS);
        wr(1'b0, 8'h02);
        chk("alt", 104'(1'b0), 104'(row_pins_alt));
        wr(1'b0, CMD_DESELECT);
        wr(1'b0, 8'h7F);
        chk("deselect", 104'(7'h7F), 104'(deselect));
        wr(1'b0, CMD_AREA_POWER);
        wr(1'b0, 8'h35);
        chk("mode", 104'(2'b11), 104'({area_colour, low_power}));
        wr(1'b0, CMD_CONTRAST);
        wr(1'b0, 8'hFF);
        wr(1'b0, CMD_PULSE_TABLE);
        foreach (lut_par[i]) wr(1'b0, lut_par[i]);
        chk("contrast", 104'(8'hFF), 104'(contrast));
        chk("pulse", (|row_out[15:0]) ? 104'(6'h19) : 104'(6'h01), 104'(pulse));
        wr(1'b0, 8'hC8);
        chk("flip", (|row_out[47:32]) ? 104'(6'h19) : 104'(6'h01), 104'(pulse));
        wr(1'b0, 8'hAF);
        chk("oe", 104'(2'b11), 104'({&col_oe, &row_oe}));
        rd(1'b0, 8'h00, 1'b1);
        wr(1'b0, 8'hA7);
        wr(1'b0, 8'hA5);
        repeat (600) @(negedge clock);
        chk("pixels", {104{1'b1}}, col_out);
        wr(1'b0, CMD_ENTIRE_ON);
        wr(1'b0, CMD_INVERSE);
        wr(1'b0, CMD_DISPLAY);
        chk("oe", 104'(2'b00), 104'({|col_oe, |row_oe}));
        ptr(7'h00);
        wr(1'b1, 8'h11);
        wr(1'b1, 8'h22);
        wr(1'b1, 8'h33);
        ptr(LAST_COL);
        wr(1'b1, 8'hAA);
        wr(1'b1, 8'hBB);
        ptr(LAST_COL);
        rd(1'b1, 8'h00, 1'b0);
        rd(1'b0, 8'h40, 1'b1);
        rd(1'b1, 8'hAA, 1'b1);
        wr(1'b0, CMD_INVERSE);
        rd(1'b1, 8'hBB, 1'b1);
        rd(1'b1, 8'h22, 1'b1);
        rmw = 1'b1;
        ptr(7'h00);
        rd(1'b1, 8'h00, 1'b0);
        rd(1'b1, 8'hBB, 1'b1);
        rd(1'b1, 8'hBB, 1'b1);
        rmw = 1'b0;
        wr(1'b0, CMD_SCROLL_OFF);
        wr(1'b0, CMD_SCROLL_SET);
        foreach (scr_par[i]) wr(1'b0, scr_par[i]);
        wr(1'b0, CMD_CONTRAST);
        wr(1'b0, 8'h34);
        chk("contrast", 104'(8'h34), 104'(contrast));
        wr(1'b0, CMD_SCROLL_ON);
        chk("scroll", 104'(1'b1), 104'(scroll_active));
        wr(1'b0, CMD_SCROLL_OFF);
        chk("scroll", 104'(1'b0), 104'(scroll_active));
        wr(1'b0, CMD_LOCK);
        wr(1'b0, 8'h04);
        rd(1'b0, 8'hC0, 1'b1);
        wr(1'b0, CMD_CONTRAST);
        wr(1'b0, 8'h77);
        chk("contrast", 104'(8'h34), 104'(contrast));
        wr(1'b0, CMD_LOCK);
        wr(1'b0, 8'h00);
        rd(1'b0, 8'h40, 1'b1);
        serial_mode = 1'b1;
        repeat (6) @(negedge clock);
        rd(1'b0, 8'h00, 1'b0);
        wr(1'b0, CMD_CONTRAST);
        wr(1'b0, 8'h55);
        chk("contrast", 104'(8'h55), 104'(contrast));
        final_report();
    end
endmodule : odc_decoder_test
